// ==== core/e1ts_pkg.sv ====
// shared constants, config and word layouts, edge selection helper
// assumes one E1 framer fed from a common backplane bit clock
`default_nettype none

package e1ts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam logic [7:0] FIRST_BIT_POS    = 8'h00;
  localparam logic [7:0] LAST_BIT_POS     = 8'hFF;
  localparam logic [2:0] LAST_BIT_IN_SLOT = 3'h7;
  localparam logic [4:0] SIG_SLOT         = 5'h10;
  localparam logic [3:0] FIRST_FRAME      = 4'h0;
  localparam logic [3:0] FRAME_STEP       = 4'h1;
  localparam logic [7:0] BIT_STEP         = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // select encodings
  localparam logic EDGE_FALL     = 1'b0;
  localparam logic EDGE_RISE     = 1'b1;
  localparam logic RATE_SINGLE   = 1'b0;
  localparam logic RATE_DOUBLE   = 1'b1;
  localparam logic FPTYPE_BASIC  = 1'b0;
  localparam logic FPTYPE_MULTI  = 1'b1;
  localparam logic SIGNALING_SOURCE_SEL_EXT    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RST_SYNC   = 2'h3;
  localparam logic       RST_PHASE  = 1'b0;
  localparam logic       RST_TGL    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // clocks
  localparam int unsigned CORE_CLK_PERIOD_NS = 8;
  localparam int unsigned DATA_RATE_KBPS     = 2048;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic ext_sig_mode;
    logic backplane_clock_rate_sel;
    logic frame_pulse_edge_sel;
    logic data_edge_sel;
    logic frame_sync_out_edge_sel;
    logic half_bit_edge_offset;
    logic frame_pulse_type_sel;
    logic frame_pulse_polarity_sel;
    logic ccs_disabled;
    logic signaling_source_sel;
  } e1ts_cfg_t;

  localparam e1ts_cfg_t RST_CFG = '0;

  typedef struct packed {
    logic [3:0] frame;
    logic [4:0] slot;
    logic [7:0] data;
    logic [7:0] sig;
  } e1ts_word_t;

  localparam e1ts_word_t RST_WORD = '0;

  typedef enum logic [1:0] {
    E1TS_HUNT   = 2'b00,
    E1TS_LOCKED = 2'b01
  } e1ts_align_t;

  ////////////////////////////////////////////////////////////////////////////
  // picks a sample; a falling select paired with a rising reference
  // takes the falling edge one edge earlier, and vice versa
  function automatic logic e1ts_edge_pick(input logic own_rise,
                                          input logic ref_rise,
                                          input logic rise_s,
                                          input logic rise_d,
                                          input logic fall_d);
    logic v;
    v = fall_d;
    if (own_rise) begin
      v = ref_rise ? rise_s : rise_d;
    end
    return v;
  endfunction

endpackage

`default_nettype wire

// ==== core/e1ts_edge_sampler.sv ====
// samples one backplane input on both edges of the bit clock
// assumes the pin is timed to the bit clock and link reset is synchronous release
`default_nettype none

module e1ts_edge_sampler
  import e1ts_pkg::*;
(
  input  wire logic bck,
  input  wire logic link_rst,
  input  wire logic link_ce,
  input  wire logic pin_in,
  output logic      rise_r,
  output logic      rise_d_r,
  output logic      fall_d_r
);

  logic fall_r;

  ////////////////////////////////////////////////////////////////////////////
  // rising edge samples
  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      rise_r   <= 1'b0;
      rise_d_r <= 1'b0;
    end else if (link_ce) begin
      rise_r   <= pin_in;
      rise_d_r <= rise_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling edge sample
  always_ff @(negedge bck or posedge link_rst) begin
    if (link_rst) begin
      fall_r <= 1'b0;
    end else if (link_ce) begin
      fall_r <= pin_in;
    end
  end

  // falling sample realigned to rising edges
  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      fall_d_r <= 1'b0;
    end else if (link_ce) begin
      fall_d_r <= fall_r;
    end
  end

endmodule // e1ts_edge_sampler

`default_nettype wire

// ==== core/e1ts_backplane_rx.sv ====
// transmit backplane receiver for one E1 framer, clock slave mode
// assumes backplane pins are timed to common_tx_bit_clock; cfg is quasi-static
`default_nettype none

module e1ts_backplane_rx
  import e1ts_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire e1ts_cfg_t  cfg,
  input  wire logic       common_tx_bit_clock,
  input  wire logic       common_tx_frame_pulse,
  input  wire logic       tx_serial_data_in,
  input  wire logic       tx_signaling_in,
  output logic            tx_frame_sync_out,
  output logic            tx_frame_sync_out_oe,
  output e1ts_word_t      word_out,
  output logic            word_valid,
  output logic            frame_aligned
);

  logic        bck;
  logic [1:0]  lrst_r;
  logic        link_rst;
  logic        ce_meta_r;
  logic        link_ce_r;
  e1ts_cfg_t   cfg_meta_r;
  e1ts_cfg_t   cfg_r;
  logic [1:0]  cfg_vld_r;
  logic        fp_rise_s;
  logic        fp_rise_d;
  logic        fp_fall_d;
  logic        sd_rise_s;
  logic        sd_rise_d;
  logic        sd_fall_d;
  logic        sg_rise_s;
  logic        sg_rise_d;
  logic        sg_fall_d;
  logic        fp_s;
  logic        fp_act;
  logic        fp_prev_r;
  logic        fp_start;
  logic        data_s;
  logic        sig_s;
  logic        phase_r;
  logic        cur_phase;
  logic        bit_stb;
  logic        align_pend_r;
  logic        align_now;
  logic [7:0]  bit_pos_r;
  logic [7:0]  cur_pos;
  logic [3:0]  frame_r;
  logic [3:0]  cur_frame;
  logic [7:0]  data_sh_r;
  logic [7:0]  sig_sh_r;
  logic [7:0]  data_byte;
  logic [7:0]  sig_byte;
  logic        subst;
  e1ts_align_t state_r;
  e1ts_align_t state_nxt;
  e1ts_word_t  link_word_r;
  logic        link_tgl_r;
  logic        fs_src_r;
  logic        fs_neg_r;
  logic        oe_r;
  logic        tgl_meta_r;
  logic        tgl_sync_r;
  logic        tgl_seen_r;
  logic        lock_meta_r;

  ////////////////////////////////////////////////////////////////////////////
  // link clock, reset release and control crossing
  // common bit clock
  assign bck      = common_tx_bit_clock;
  assign link_rst = lrst_r[1];

  always_ff @(posedge bck or posedge rst) begin
    if (rst) begin
      lrst_r <= RST_SYNC;
    end else begin
      lrst_r <= {lrst_r[0], 1'b0};
    end
  end

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      ce_meta_r <= 1'b0;
      link_ce_r <= 1'b0;
    end else begin
      ce_meta_r <= ce;
      link_ce_r <= ce_meta_r;
    end
  end

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      cfg_meta_r <= RST_CFG;
      cfg_r      <= RST_CFG;
      cfg_vld_r  <= 2'h0;
    end else if (link_ce_r) begin
      cfg_meta_r <= cfg;
      cfg_r      <= cfg_meta_r;
      cfg_vld_r  <= {cfg_vld_r[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling on both clock edges
  e1ts_edge_sampler u_fp_smp (
    .bck      (bck),
    .link_rst (link_rst),
    .link_ce  (link_ce_r),
    .pin_in   (common_tx_frame_pulse),
    .rise_r   (fp_rise_s),
    .rise_d_r (fp_rise_d),
    .fall_d_r (fp_fall_d)
  );

  e1ts_edge_sampler u_sd_smp (
    .bck      (bck),
    .link_rst (link_rst),
    .link_ce  (link_ce_r),
    .pin_in   (tx_serial_data_in),
    .rise_r   (sd_rise_s),
    .rise_d_r (sd_rise_d),
    .fall_d_r (sd_fall_d)
  );

  e1ts_edge_sampler u_sg_smp (
    .bck      (bck),
    .link_rst (link_rst),
    .link_ce  (link_ce_r),
    .pin_in   (tx_signaling_in),
    .rise_r   (sg_rise_s),
    .rise_d_r (sg_rise_d),
    .fall_d_r (sg_fall_d)
  );

  ////////////////////////////////////////////////////////////////////////////
  // edge selection
  // pulse edge select
  assign fp_s = e1ts_edge_pick(cfg_r.frame_pulse_edge_sel, cfg_r.data_edge_sel,
                               fp_rise_s, fp_rise_d, fp_fall_d);
  assign data_s = e1ts_edge_pick(cfg_r.data_edge_sel, cfg_r.data_edge_sel,
                                 sd_rise_s, sd_rise_d, sd_fall_d);
  assign sig_s  = e1ts_edge_pick(cfg_r.data_edge_sel, cfg_r.data_edge_sel,
                                 sg_rise_s, sg_rise_d, sg_fall_d);

  assign fp_act   = fp_s ^ cfg_r.frame_pulse_polarity_sel;
  assign fp_start = fp_act & ~fp_prev_r & cfg_vld_r[1];

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      fp_prev_r <= 1'b0;
    end else if (link_ce_r) begin
      fp_prev_r <= fp_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-bit phase for double rate clock
  // rate select
  assign cur_phase = fp_start ? RST_PHASE : phase_r;
  assign bit_stb   = (cfg_r.backplane_clock_rate_sel == RATE_SINGLE) |
                     (cur_phase == cfg_r.half_bit_edge_offset);

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      phase_r      <= RST_PHASE;
      align_pend_r <= 1'b0;
    end else if (link_ce_r) begin
      phase_r      <= ~cur_phase;
      align_pend_r <= align_now & ~bit_stb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit and frame counters
  // pulse aligns bit counter
  assign align_now = fp_start | align_pend_r;
  assign cur_pos   = align_now ? FIRST_BIT_POS : bit_pos_r;
  assign cur_frame = (align_now & (cfg_r.frame_pulse_type_sel == FPTYPE_MULTI)) ?
                     FIRST_FRAME : frame_r;

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      bit_pos_r <= FIRST_BIT_POS;
      frame_r   <= FIRST_FRAME;
    end else if (link_ce_r && bit_stb) begin
      bit_pos_r <= cur_pos + BIT_STEP;
      frame_r   <= (cur_pos == LAST_BIT_POS) ? cur_frame + FRAME_STEP : cur_frame;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alignment state
  always_comb begin
    unique case (state_r)
      E1TS_HUNT:   state_nxt = fp_start ? E1TS_LOCKED : E1TS_HUNT;
      E1TS_LOCKED: state_nxt = E1TS_LOCKED;
      default:     state_nxt = E1TS_HUNT;
    endcase
  end

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      state_r <= E1TS_HUNT;
    end else if (link_ce_r) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte assembly
  // first bit lands in msb
  assign data_byte = {data_sh_r[6:0], data_s};
  assign sig_byte  = {sig_sh_r[6:0], sig_s};
  assign subst = cfg_r.ext_sig_mode & cfg_r.ccs_disabled &
                 (cfg_r.signaling_source_sel == SIGNALING_SOURCE_SEL_EXT) &
                 (cur_pos[7:3] == SIG_SLOT);

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      data_sh_r <= RST_BYTE;
      sig_sh_r  <= RST_BYTE;
    end else if (link_ce_r && bit_stb) begin
      data_sh_r <= data_byte;
      sig_sh_r  <= sig_byte;
    end
  end

  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      link_word_r <= RST_WORD;
      link_tgl_r  <= RST_TGL;
    end else if (link_ce_r && bit_stb && (cur_pos[2:0] == LAST_BIT_IN_SLOT) &&
                 (state_r == E1TS_LOCKED)) begin
      link_word_r.frame <= cur_frame;
      link_word_r.slot  <= cur_pos[7:3];
      link_word_r.data  <= subst ? sig_byte : data_byte;
      link_word_r.sig   <= cfg_r.ext_sig_mode ? sig_byte : RST_BYTE;
      link_tgl_r        <= ~link_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sync output on the shared pin
  // pulse on first frame bit
  always_ff @(posedge bck or posedge link_rst) begin
    if (link_rst) begin
      fs_src_r <= 1'b0;
      oe_r     <= 1'b0;
    end else if (link_ce_r) begin
      oe_r <= ~cfg_r.ext_sig_mode;
      if (bit_stb) begin
        fs_src_r <= ~cfg_r.ext_sig_mode & (state_nxt == E1TS_LOCKED) & (cur_pos == LAST_BIT_POS);
      end
    end
  end

  always_ff @(negedge bck or posedge link_rst) begin
    if (link_rst) begin
      fs_neg_r <= 1'b0;
    end else if (link_ce_r) begin
      fs_neg_r <= fs_src_r;
    end
  end

  assign tx_frame_sync_out = (cfg_r.frame_sync_out_edge_sel == EDGE_RISE) ?
                             fs_src_r : fs_neg_r;
  // pin is input in signaling mode
  assign tx_frame_sync_out_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // word and lock crossing into core clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tgl_meta_r <= RST_TGL;
      tgl_sync_r <= RST_TGL;
      tgl_seen_r <= RST_TGL;
    end else if (ce) begin
      tgl_meta_r <= link_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_out   <= RST_WORD;
      word_valid <= 1'b0;
    end else if (ce) begin
      word_valid <= tgl_sync_r ^ tgl_seen_r;
      if (tgl_sync_r ^ tgl_seen_r) begin
        word_out <= link_word_r;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_meta_r   <= 1'b0;
      frame_aligned <= 1'b0;
    end else if (ce) begin
      lock_meta_r   <= (state_r == E1TS_LOCKED);
      frame_aligned <= lock_meta_r;
    end
  end

endmodule // e1ts_backplane_rx

`default_nettype wire

// ==== verif/e1ts_backplane_rx_checker.sv ====
// checker for the backplane receiver, on its ports
// assumes cfg only changes under reset
`default_nettype none

module e1ts_backplane_rx_checker
  import e1ts_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       common_tx_bit_clock,
  input wire e1ts_cfg_t  cfg,
  input wire logic       tx_frame_sync_out,
  input wire logic       tx_frame_sync_out_oe,
  input wire e1ts_word_t word_out,
  input wire logic       word_valid,
  input wire logic       frame_aligned
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // settle and word gap counters
  logic [5:0] settle_r;
  logic [7:0] gap_r;
  logic       seen_r;
  logic       dbl;
  assign dbl = cfg.backplane_clock_rate_sel;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_r <= 6'h00;
    end else if (settle_r != 6'h3F) begin
      settle_r <= settle_r + 6'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (word_valid) begin
      gap_r <= 8'h00;
      seen_r <= 1'b1;
    end else if (gap_r != 8'hFF) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_word_gap: assert property (
    word_valid && seen_r |-> gap_r >= (dbl ? 8'h3D : 8'h1D) && gap_r <= (dbl ? 8'h41 : 8'h21))
    else $error("word spacing off");
  a_valid_pulse: assert property (word_valid |=> !word_valid)
    else $error("valid longer than one cycle");
  a_valid_locked: assert property (word_valid |-> frame_aligned)
    else $error("word before alignment");
  a_lock_sticky: assert property (frame_aligned |=> frame_aligned)
    else $error("alignment dropped");
  a_word_holds: assert property (!word_valid |-> $stable(word_out))
    else $error("word changed without valid");
  a_oe_mode: assert property (
    settle_r == 6'h3F |-> tx_frame_sync_out_oe == !cfg.ext_sig_mode)
    else $error("pin direction wrong");
  a_fs_quiet: assert property (
    settle_r == 6'h3F && cfg.ext_sig_mode |-> !tx_frame_sync_out)
    else $error("frame sync in signaling mode");
  a_fs_one_bit: assert property (
    $rose(tx_frame_sync_out) && !dbl |-> tx_frame_sync_out[*3] ##[1:3] !tx_frame_sync_out)
    else $error("frame sync width single");
  a_fs_two_bck: assert property (
    $rose(tx_frame_sync_out) && dbl |-> tx_frame_sync_out[*7] ##[1:3] !tx_frame_sync_out)
    else $error("frame sync width double");
  a_fs_edge: assert property (
    $changed(tx_frame_sync_out) |-> common_tx_bit_clock == cfg.frame_sync_out_edge_sel)
    else $error("frame sync on wrong edge");
endmodule // e1ts_backplane_rx_checker

bind e1ts_backplane_rx e1ts_backplane_rx_checker chk_u (
  .core_clk(core_clk), .rst(rst), .cfg(cfg), .tx_frame_sync_out(tx_frame_sync_out),
  .common_tx_bit_clock(common_tx_bit_clock),
  .tx_frame_sync_out_oe(tx_frame_sync_out_oe), .word_out(word_out),
  .word_valid(word_valid), .frame_aligned(frame_aligned));

`default_nettype wire

// ==== verif/e1ts_bp_master.sv ====
// backplane master model: bit clock, frame pulse, data, signaling
// assumes cfg steady while en is high
`default_nettype none

module e1ts_bp_master
  import e1ts_pkg::*;
(
  input  wire logic       en,
  input  wire e1ts_cfg_t  cfg,
  input  wire logic [7:0] seed,
  output logic            bck,
  output logic            fp,
  output logic            sd,
  output logic            sig
);
  timeunit 1ns;
  timeprecision 1ps;

  int         pos;
  int         frm;
  logic [7:0] db;
  logic [7:0] sb;

  initial begin
    bck = 1'b0;
    forever #16 bck = ~bck;
  end

  task automatic edge_of(input logic rise);
    if (rise) @(posedge bck);
    else @(negedge bck);
  endtask

  // pulse per frame or multiframe, polarity
  function automatic logic pulse_lvl();
    return ((pos == 0) && (!cfg.frame_pulse_type_sel || frm % 16 == 0))
      ^ cfg.frame_pulse_polarity_sel;
  endfunction

  always @(cfg) if (!en) fp <= cfg.frame_pulse_polarity_sel;

  initial begin
    sd = 1'b0;
    sig = 1'b0;
    forever begin
      @(posedge en);
      pos = 240;
      frm = -1;
      while (en) begin
        edge_of(cfg.data_edge_sel);
        if (cfg.backplane_clock_rate_sel) edge_of(cfg.data_edge_sel);
        // opposite pulse edge to data, driven one edge early
        if (cfg.frame_pulse_edge_sel != cfg.data_edge_sel) fp <= pulse_lvl();
        edge_of(!cfg.data_edge_sel);
        db = seed + 8'(frm * 37 + pos / 8 * 11);
        sb = seed ^ 8'(frm * 5 + pos / 8);
        sd <= db[7 - pos % 8];
        sig <= sb[7 - pos % 8];
        if (cfg.frame_pulse_edge_sel == cfg.data_edge_sel) fp <= pulse_lvl();
        pos = (pos + 1) % 256;
        if (pos == 0) frm++;
      end
    end
  end
endmodule // e1ts_bp_master

`default_nettype wire

// ==== verif/e1ts_backplane_rx_tb.sv ====
// bench: runs configs through the receiver, checks every word
// assumes master model and checker are compiled first
`default_nettype none

module e1ts_backplane_rx_tb
  import e1ts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("FAIL %0t got %h exp %h", $time, a, b); end end

  logic       core_clk, rst, ce, en, bck, fp, sd, sig, pin;
  logic       fs, fs_oe, wv, al;
  logic [7:0] seed;
  e1ts_cfg_t  cfg;
  e1ts_word_t wo;
  int         num_errors = 0;
  int         tests_run = 0;
  int         idx = 0;
  int         cyc = 0;
  e1ts_cfg_t  runs [6] = '{10'h0E0, 10'h044, 10'h28A, 10'h207, 10'h1F0, 10'h30A};

  // shared pin resolved from fs_oe alone: frame sync when high, else signaling
  assign pin = fs_oe ? fs : sig;

  e1ts_backplane_rx dut_u (
    .core_clk(core_clk), .rst(rst), .ce(ce), .cfg(cfg), .common_tx_bit_clock(bck),
    .common_tx_frame_pulse(fp), .tx_serial_data_in(sd), .tx_signaling_in(pin),
    .tx_frame_sync_out(fs), .tx_frame_sync_out_oe(fs_oe), .word_out(wo),
    .word_valid(wv), .frame_aligned(al));

  e1ts_bp_master mst_u (.en(en), .cfg(cfg), .seed(seed), .bck(bck), .fp(fp), .sd(sd),
    .sig(sig));

  function automatic e1ts_word_t exp_word(int i, e1ts_cfg_t c, logic [7:0] s);
    e1ts_word_t w;
    int         f;
    int         t;
    logic [7:0] g;
    f = i / 32;
    t = i % 32;
    g = s ^ 8'(f * 5 + t);
    w.frame = 4'(f);
    w.slot = 5'(t);
    w.sig = c.ext_sig_mode ? g : 8'h00;
    w.data = s + 8'(f * 37 + t * 11);
    if (c.ext_sig_mode && c.ccs_disabled && c.signaling_source_sel == SIGNALING_SOURCE_SEL_EXT && t == 16)
      w.data = g;
    return w;
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 32'h0001_3880) begin
      num_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word checks
  always @(negedge core_clk) begin
    if (!rst && wv) begin
      `CHK(wo, exp_word(idx, cfg, seed))
      idx++;
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    en = 1'b0;
    cfg = RST_CFG;
    seed = 8'h00;
    void'($urandom(24));
    for (int r = 0; r < 8; r++) begin
      @(negedge core_clk);
      rst = 1'b1;
      en = 1'b0;
      cfg = (r < 6) ? runs[r] : e1ts_cfg_t'(10'($urandom));
      if (cfg.backplane_clock_rate_sel) cfg.frame_pulse_edge_sel = cfg.data_edge_sel;
      seed = 8'($urandom);
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      idx = 0;
      en = 1'b1;
      while (idx < 96) @(negedge core_clk);
      `CHK(al, 1'b1)
      en = 1'b0;
    end
    test_done();
  end
endmodule // e1ts_backplane_rx_tb

`default_nettype wire
